// >>> verilog/cswd_pkg.sv
package cswd_pkg;

   // Frame layout, bit positions within the 24-bit command
   localparam int CSWD_FRAME_W = 24;
   localparam int CSWD_FRAME_BYTES = 3;
   localparam int CSWD_POS_ADDR_HI = 23;
   localparam int CSWD_POS_ADDR_LO = 17;
   localparam int CSWD_POS_RW = 16;
   localparam int CSWD_POS_DATA = 15;
   localparam int CSWD_POS_ROW_HI = 14;
   localparam int CSWD_POS_ROW_LO = 11;
   localparam int CSWD_POS_COL_HI = 10;
   localparam int CSWD_POS_COL_LO = 8;
   localparam int CSWD_POS_LOAD = 0;

   // Fixed upper address bits
   localparam logic [3:0] CSWD_ADDR_FIXED = 4'he;

   // Row code map: two runs of valid codes
   localparam logic [3:0] CSWD_ROW_A_FIRST = 4'h2;
   localparam logic [3:0] CSWD_ROW_A_LAST = 4'h5;
   localparam logic [3:0] CSWD_ROW_B_FIRST = 4'h8;
   localparam logic [3:0] CSWD_ROW_B_LAST = 4'hd;
   localparam logic [3:0] CSWD_ROW_B_BASE = 4'h4;

   // Array geometry
   localparam int CSWD_NUM_ROWS = 10;
   localparam int CSWD_NUM_COLS = 8;

   // Serial bit counting
   localparam logic [3:0] CSWD_BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] CSWD_LAST_BYTE = 2'h2;

   // Reset values
   localparam logic CSWD_LINE_IDLE = 1'b1;

   typedef enum logic [1:0] {
      CSWD_IDLE,
      CSWD_BITS,
      CSWD_ACK,
      CSWD_SKIP
   } cswd_rx_state_t;

endpackage

// >>> verilog/cswd_frame_if.sv
`timescale 1ns/100ps
interface cswd_frame_if;
   import cswd_pkg::*;
   logic valid;
   logic [CSWD_FRAME_W-1:0] cmd;
   modport src (output valid, output cmd);
   modport dst (input valid, input cmd);
endinterface

// >>> verilog/cswd_sync.sv
`timescale 1ns/100ps
module cswd_sync
   import cswd_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] q_r;

   // First stage feeds only the second
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         meta_r <= INIT;
         q_r <= INIT;
      end
      else
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;

endmodule

// >>> verilog/cswd_switch_bank.sv
`timescale 1ns/100ps
module cswd_switch_bank
   import cswd_pkg::*;
#(
   parameter int NUM_ROWS = CSWD_NUM_ROWS,
   parameter int NUM_COLS = CSWD_NUM_COLS
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   cswd_frame_if.dst frm,
   output logic [NUM_ROWS*NUM_COLS-1:0] switch_closed,
   output logic [NUM_ROWS*NUM_COLS-1:0] switch_pending
);

   localparam int NSW = NUM_ROWS * NUM_COLS;

   wire [3:0] row_line_select = frm.cmd[CSWD_POS_ROW_HI:CSWD_POS_ROW_LO];
   wire [2:0] column_line_select = frm.cmd[CSWD_POS_COL_HI:CSWD_POS_COL_LO];
   wire set_closed = frm.cmd[CSWD_POS_DATA];
   wire switch_load_strobe = frm.cmd[CSWD_POS_LOAD];

   // Two runs of legal codes, the rest reserved
   wire row_in_a = (row_line_select >= CSWD_ROW_A_FIRST) && (row_line_select <= CSWD_ROW_A_LAST);
   wire row_in_b = (row_line_select >= CSWD_ROW_B_FIRST) && (row_line_select <= CSWD_ROW_B_LAST);
   wire row_ok = row_in_a | row_in_b;
   wire [3:0] row_idx = row_in_a ? row_line_select - CSWD_ROW_A_FIRST
                                 : row_line_select - CSWD_ROW_B_BASE;
   // Reserved row code touches nothing
   wire cmd_ok = frm.valid & row_ok;
   wire apply = cmd_ok & switch_load_strobe;

   logic [NSW-1:0] pend_r;
   logic [NSW-1:0] pend_nxt;
   logic [NSW-1:0] act_r;
   logic [NSW-1:0] act_nxt;

   genvar i;
   generate
      for (i = 0; i < NSW; i++)
      begin : g_sw
         wire hit = cmd_ok && (row_idx == 4'(i / NUM_COLS))
                           && (column_line_select == 3'(i % NUM_COLS));
         // Only the addressed cell moves
         assign pend_nxt[i] = hit ? set_closed : pend_r[i];
      end
   endgenerate

   // Whole pending image goes live at once
   assign act_nxt = apply ? pend_nxt : act_r;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pend_r <= '0;
         act_r <= '0;
      end
      else
      begin
         pend_r <= pend_nxt;
         act_r <= act_nxt;
      end
   end

   assign switch_closed = act_r;
   assign switch_pending = pend_r;

endmodule

// >>> verilog/cswd_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Hold a 24-bit serial command shift register
// - Each command is exactly three bytes on SCL
// - Answer only address 1110 plus three straps
// - Bit after address: one read, zero write
// - Data bit: zero opens, one closes switch
// - Four-bit field selects one of ten rows
// - Three-bit field below selects one of eight columns
// - Row codes map to rows; six codes reserved
// - Column field is a plain binary index
// - Load bit one with a valid row code applies all pending settings
// - Load bit zero latches without moving switches
// - Only the addressed switch's pending state changes
// - Reset opens all switches, clears the receive and switch registers, sets SCL/SDA history to idle high
// - Chained writes with load last update together

module cswd_top
   import cswd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_strap_0,
   input wire logic addr_strap_1,
   input wire logic addr_strap_2,
   output logic [CSWD_NUM_ROWS*CSWD_NUM_COLS-1:0] switch_closed,
   output logic [CSWD_NUM_ROWS*CSWD_NUM_COLS-1:0] switch_pending,
   output logic frame_strobe,
   output logic link_busy
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic scl_s;
   logic sda_s;
   logic [2:0] strap_s;

   cswd_sync #(
      .WIDTH(1),
      .INIT(CSWD_LINE_IDLE)
   ) u_scl_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .d(scl_in),
      .q(scl_s)
   );

   // Same depth as the clock lane, so data keeps its setup to SCL
   cswd_sync #(
      .WIDTH(1),
      .INIT(CSWD_LINE_IDLE)
   ) u_sda_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .d(sda_in),
      .q(sda_s)
   );

   // Straps are static, but still pins from outside
   cswd_sync #(
      .WIDTH(3),
      .INIT(3'h0)
   ) u_strap_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .d({addr_strap_2, addr_strap_1, addr_strap_0}),
      .q(strap_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Line edge and bus condition detection

   logic scl_d_r;
   logic sda_d_r;

   // History starts at idle so reset release shows no false edge
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         scl_d_r <= CSWD_LINE_IDLE;
      end
      else
      begin
         scl_d_r <= scl_s;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sda_d_r <= CSWD_LINE_IDLE;
      end
      else
      begin
         sda_d_r <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire scl_high = scl_s & scl_d_r;
   // SDA moving while SCL stays high marks frame bounds
   wire start_seen = scl_high & sda_d_r & ~sda_s;
   wire stop_seen = scl_high & ~sda_d_r & sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // Receive state

   cswd_rx_state_t state_r;
   cswd_rx_state_t state_nxt;
   logic [3:0] bit_cnt_r;
   logic [3:0] bit_cnt_nxt;
   logic [1:0] byte_cnt_r;
   logic [1:0] byte_cnt_nxt;
   logic [CSWD_FRAME_W-1:0] switch_command_shift_r;
   logic [CSWD_FRAME_W-1:0] switch_command_shift_nxt;
   logic ack_r;
   logic ack_nxt;
   logic fire_r;
   logic fire_nxt;
   logic busy_r;

   ////////////////////////////////////////////////////////////////////////////
   // Byte and address decode

   wire [6:0] own_addr = {CSWD_ADDR_FIXED, strap_s[2], strap_s[1], strap_s[0]};
   // Address byte sits in the low byte right after its eighth bit
   wire [6:0] rx_addr = switch_command_shift_r[7:1];
   wire addr_match = (rx_addr == own_addr);
   // Readback is not offered, so a read request is left unanswered
   wire is_write = ~switch_command_shift_r[0];
   wire first_byte = (byte_cnt_r == 2'h0);
   wire last_byte = (byte_cnt_r == CSWD_LAST_BYTE);
   wire byte_ok = ~first_byte | (addr_match & is_write);
   wire byte_full = (bit_cnt_r == CSWD_BITS_PER_BYTE);
   wire take_bit = scl_rise & ~byte_full;
   wire byte_end = scl_fall & byte_full;
   wire [3:0] bit_cnt_inc = bit_cnt_r + 4'h1;
   wire [1:0] byte_cnt_inc = byte_cnt_r + 2'h1;
   // MSB first into the 24-bit register
   wire [CSWD_FRAME_W-1:0] shift_in = {switch_command_shift_r[CSWD_FRAME_W-2:0],
                                       sda_s};
   // Busy follows the next state so the registered pin matches the FSM
   wire busy_nxt = (state_nxt != CSWD_IDLE);

   always_comb
   begin
      state_nxt = state_r;
      bit_cnt_nxt = bit_cnt_r;
      byte_cnt_nxt = byte_cnt_r;
      switch_command_shift_nxt = switch_command_shift_r;
      ack_nxt = ack_r;
      fire_nxt = 1'b0;
      if (stop_seen)
      begin
         // Partial frame is dropped
         state_nxt = CSWD_IDLE;
         ack_nxt = 1'b0;
      end
      else if (start_seen)
      begin
         // Repeated start also restarts counting
         state_nxt = CSWD_BITS;
         bit_cnt_nxt = 4'h0;
         byte_cnt_nxt = 2'h0;
         ack_nxt = 1'b0;
      end
      else
      begin
         unique case (state_r)
            CSWD_IDLE:
            begin
               state_nxt = CSWD_IDLE;
            end
            CSWD_BITS:
            begin
               if (take_bit)
               begin
                  switch_command_shift_nxt = shift_in;
                  bit_cnt_nxt = bit_cnt_inc;
               end
               else if (byte_end)
               begin
                  if (byte_ok)
                  begin
                     state_nxt = CSWD_ACK;
                     ack_nxt = 1'b1;
                     // Third byte complete: hand the frame on
                     fire_nxt = last_byte;
                  end
                  else
                  begin
                     state_nxt = CSWD_SKIP;
                  end
               end
            end
            CSWD_ACK:
            begin
               if (scl_fall)
               begin
                  ack_nxt = 1'b0;
                  bit_cnt_nxt = 4'h0;
                  byte_cnt_nxt = byte_cnt_inc;
                  // Bytes past the third are not acknowledged
                  state_nxt = last_byte ? CSWD_SKIP : CSWD_BITS;
               end
            end
            CSWD_SKIP:
            begin
               state_nxt = CSWD_SKIP;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_r <= CSWD_IDLE;
         bit_cnt_r <= 4'h0;
         byte_cnt_r <= 2'h0;
      end
      else
      begin
         state_r <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         byte_cnt_r <= byte_cnt_nxt;
      end
   end

   // Not cleared per frame: 24 new bits overwrite it
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         switch_command_shift_r <= '0;
      end
      else
      begin
         switch_command_shift_r <= switch_command_shift_nxt;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ack_r <= 1'b0;
         fire_r <= 1'b0;
      end
      else
      begin
         ack_r <= ack_nxt;
         fire_r <= fire_nxt;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         busy_r <= 1'b0;
      end
      else
      begin
         busy_r <= busy_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame hand-off and switch array

   cswd_frame_if frm ();

   // Low byte bits 7..1 never reach the bank's decode
   assign frm.valid = fire_r;
   assign frm.cmd = switch_command_shift_r;

   cswd_switch_bank #(
      .NUM_ROWS(CSWD_NUM_ROWS),
      .NUM_COLS(CSWD_NUM_COLS)
   ) u_bank (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .frm(frm),
      .switch_closed(switch_closed),
      .switch_pending(switch_pending)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = ack_r;
   assign frame_strobe = fire_r;
   assign link_busy = busy_r;

endmodule

// >>> tb/cswd_top_asserts.sv
`timescale 1ns/100ps
module cswd_top_asserts
   import cswd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic addr_strap_0,
   input wire logic addr_strap_1,
   input wire logic addr_strap_2,
   input wire logic [CSWD_NUM_ROWS*CSWD_NUM_COLS-1:0] switch_closed,
   input wire logic [CSWD_NUM_ROWS*CSWD_NUM_COLS-1:0] switch_pending,
   input wire logic frame_strobe,
   input wire logic link_busy
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   property p_pull;
      sda_out == 1'b0;
   endproperty
   a_pull: assert property (p_pull) else $error("sda_out not low");
   property p_oe_busy;
      sda_oe |-> link_busy;
   endproperty
   a_oe_busy: assert property (p_oe_busy) else $error("ack outside frame");
   property p_oe_len;
      $rose(sda_oe) |-> sda_oe [*4] ##[1:8] !sda_oe;
   endproperty
   a_oe_len: assert property (p_oe_len) else $error("ack length wrong");
   // Reset check must stay live while reset is low
   property p_rst;
      disable iff (1'b0) !rst_n |=> switch_closed == '0 && switch_pending == '0 && !sda_oe;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_strobe;
      frame_strobe |-> link_busy ##1 !frame_strobe;
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe wrong");
   property p_strobe_ack;
      frame_strobe |-> sda_oe;
   endproperty
   a_strobe_ack: assert property (p_strobe_ack) else $error("third byte not acked");
   property p_closed_cause;
      $changed(switch_closed) |-> frame_strobe || $past(frame_strobe);
   endproperty
   a_closed_cause: assert property (p_closed_cause) else $error("stray closed");
   property p_pend_cause;
      $changed(switch_pending) |-> frame_strobe || $past(frame_strobe);
   endproperty
   a_pend_cause: assert property (p_pend_cause) else $error("stray pending");
   property p_one_bit;
      $countones(switch_pending ^ $past(switch_pending)) <= 1;
   endproperty
   a_one_bit: assert property (p_one_bit) else $error("several bits moved");
   property p_load_all;
      $changed(switch_closed) |-> switch_closed == switch_pending;
   endproperty
   a_load_all: assert property (p_load_all) else $error("load partial");
   c_frame: cover property (frame_strobe);
   c_load: cover property ($changed(switch_closed));
   c_ack: cover property ($rose(sda_oe));
endmodule
bind cswd_top cswd_top_asserts u_cswd_top_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .addr_strap_0(addr_strap_0), .addr_strap_1(addr_strap_1), .addr_strap_2(addr_strap_2),
   .switch_closed(switch_closed), .switch_pending(switch_pending),
   .frame_strobe(frame_strobe), .link_busy(link_busy));

// >>> tb/cswd_master.sv
`timescale 1ns/100ps
module cswd_master (
   input wire logic ref_clk,
   input wire logic sda_w,
   output logic scl,
   output logic sda
);
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Low 5 cycles, high 3: gives the ack time to drop before the rise
   task automatic bit_io(input logic b, output logic s);
      w(1);
      sda = b;
      w(4);
      scl = 1'b1;
      w(2);
      s = sda_w;
      w(1);
      scl = 1'b0;
   endtask
   // Fewer than three bytes gives an aborted frame
   task automatic frame(input logic [23:0] f, input int nb, output logic [2:0] ack);
      logic s;
      ack = 3'h0;
      w(4);
      sda = 1'b0;
      w(4);
      scl = 1'b0;
      for (int i = 0; i < nb; i++)
      begin
         for (int j = 7; j >= 0; j--)
            bit_io(f[8*(2-i)+j], s);
         bit_io(1'b1, s);
         ack[2-i] = ~s;
      end
      w(1);
      sda = 1'b0;
      w(4);
      scl = 1'b1;
      w(4);
      sda = 1'b1;
   endtask
endmodule

// >>> tb/cswd_top_tb.sv
`timescale 1ns/100ps
module cswd_top_tb;
   import cswd_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic scl, sda_m, sda_out, sda_oe, frame_strobe, link_busy;
   logic [2:0] strap = 3'h0;
   logic [79:0] closed, pending, exp_c, exp_p;
   logic [23:0] f;
   wire logic sda_w = sda_m & ~(sda_oe & ~sda_out);
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int strobes = 0;
   int exp_s = 0;
   int seed = 85747;
   int rnd;
   always #10 ref_clk = ~ref_clk;
   cswd_top u_cswd_top (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_0(strap[0]),
      .addr_strap_1(strap[1]), .addr_strap_2(strap[2]), .switch_closed(closed),
      .switch_pending(pending), .frame_strobe(frame_strobe), .link_busy(link_busy));
   cswd_master u_cswd_master (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda(sda_m));
   task automatic check(input string n, input logic [79:0] s, input logic [79:0] e);
      num_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      strobes += (frame_strobe === 1'b1);
      if (cyc == 40000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic send(input logic [23:0] fr, input int nb);
      logic [2:0] ack;
      logic ok;
      int r;
      ok = fr[23:20] == 4'he && fr[19:17] == strap && !fr[16];
      r = fr[14:11];
      r = (r >= 2 && r <= 5) ? r - 2 : (r >= 8 && r <= 13) ? r - 4 : -1;
      u_cswd_master.frame(fr, nb, ack);
      if (ok && nb == 3)
      begin
         exp_s++;
         if (r >= 0)
            exp_p[r*8+fr[10:8]] = fr[15];
         if (fr[0] && r >= 0)
            exp_c = exp_p;
      end
      repeat (10) @(posedge ref_clk);
      #1;
      check("ack", ack, {ok, ok && nb > 1, ok && nb > 2});
      check("closed", closed, exp_c);
      check("pending", pending, exp_p);
      check("strobes", strobes, exp_s);
      check("idle", {sda_oe, link_busy, frame_strobe}, 3'h0);
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      exp_c = '0;
      exp_p = '0;
      check("closed", closed, exp_c);
      check("pending", pending, exp_p);
      check("idle", {sda_oe, link_busy, frame_strobe}, 3'h0);
   endtask
   initial
   begin
      do_reset();
      for (int i = 0; i < 16; i++)
         send({4'he, strap, 1'b0, 1'b1, 4'(i), 3'(i), 7'h55, 1'b1}, 3);
      // Latched chain, only the last frame loads
      for (int i = 0; i < 4; i++)
         send({4'he, strap, 1'b0, 1'b1, 4'h9, 3'(i + 4), 7'h00, i == 3}, 3);
      for (int i = 0; i < 48; i++)
      begin
         rnd = $random(seed);
         if (i % 8 == 7)
            strap = rnd[2:0];
         f = rnd[23:0];
         if (rnd[31:30] != 2'h0)
            f[23:16] = {4'he, strap, 1'b0};
         send(f, (rnd[29:27] == 3'h0) ? 2 : 3);
      end
      // Second reset in mid-run, only while the bus is idle
      do_reset();
      // Matching address with the read bit set gets no answer
      send({4'he, strap, 1'b1, 1'b1, 4'h2, 3'h0, 7'h00, 1'b1}, 3);
      send({4'he, strap, 1'b0, 1'b1, 4'hd, 3'h7, 7'h7f, 1'b1}, 3);
      print_verdict();
   end
endmodule
